// file: core/ddr2_cad_pkg.sv
// Constants for the command and address input stage of a four-bank DDR2 device.
// Assumes one system clock; all memory-side pins are asynchronous to it.
// Function
// R01: Select high makes the cycle carry no command.
// R02: Command decoded jointly from select, row, column and write strobes.
// R03: Registered termination_control high switches termination on unless disabled.
// R04: Enabled termination covers all data lines, both strobe pairs, both masks.
// R05: Termination disabled in ext_mode_set_first: termination_control is ignored.
// R06: Write beat byte discarded when its write_mask is sampled high.
// R07: Write masks sampled on both strobe edges; controller gives one per beat.
// R08: group_select picks the bank for activate, read, write, single precharge.
// R09: group_select picks base or extended mode register during mode set.
// R10: Activate takes the thirteen-bit row from addr_bus.
// R11: Read and write take column and auto-precharge flag from addr_bus.
// R12: precharge_scope_bit low closes one bank, high closes all.
// R13: Single precharge closes only the bank named by group_select.
// R14: Mode set loads addr_bus op code into the selected mode register.
// R15: Inputs sampled where true clock rises and complementary clock falls.
// R16: Controller keeps clock gate high throughout reads and writes.
// R17: Ext register strobe bit 0 selects differential, 1 single-ended strobes.
// R18: Unrecognised strobe combination is treated as no operation.
// R19: Decoded bundle registered, valid for one cycle after the sampling edge.
package ddr2c_pkg;

  localparam int BANKS = 4;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;

  typedef enum logic [2:0] {DDR2C_NOP, DDR2C_MODE, DDR2C_REFRESH, DDR2C_PRECH,
                            DDR2C_ACT, DDR2C_WRITE, DDR2C_READ} ddr2c_cmd_t;

  // Mode register selection by group_select
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT1 = 2'h1;

  // Fields of the base and first extended mode registers
  localparam int BL_LSB = 0;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam int RTT_LO_BIT = 2;
  localparam int RTT_HI_BIT = 6;
  localparam int STROBE_SE_BIT = 10;
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0002;
  localparam logic [ADDR_W-1:0] EXT1_RST = 13'h0000;

  // Register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LASTCMD = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_EXT1 = 8'h10;
  localparam logic [7:0] OFS_CMDCNT = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: core/ddr2_cad.sv
// Command and address decoder of a DDR2 device with AXI4-Lite register access.
// Assumes the memory clock pins toggle well below half of clk_sys.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
module ddr2_cad
#(
  parameter int SYNC_W = 22,
  parameter int DATA_W = 20
)
(
  input wire logic clk_sys,
  input wire logic reset,
  // Memory-side pins
  input wire logic memClk,
  input wire logic memClkN,
  input wire logic selectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeStrobeN,
  input wire logic termination_control,
  input wire logic [1:0] group_select,
  input wire logic [12:0] addr_bus,
  input wire logic [15:0] dataIn,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic lower_strobe,
  // Decoded bundle
  output logic cmdValid,
  output logic [2:0] cmdCode,
  output logic [1:0] cmdBank,
  output logic [12:0] cmdAddr,
  output logic cmdAllBanks,
  output logic cmdAutoPre,
  // Termination and strobe mode
  output logic [21:0] termApply,
  output logic strobeDiff,
  // Write beats
  output logic beatValid,
  output logic [15:0] beatData,
  output logic [1:0] beatByteEn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a bit changes once stages two and three agree
  logic [SYNC_W-1:0] cmdPins;
  logic [SYNC_W-1:0] cmdS1_r, cmdS2_r, cmdS3_r, cmdF_r, cmdPrev_r;
  logic [DATA_W-1:0] datPins;
  logic [DATA_W-1:0] datS1_r, datS2_r, datS3_r, datF_r, datPrev_r;

  assign cmdPins = {memClk, memClkN, selectN, rowStrobeN, colStrobeN, writeStrobeN,
                    termination_control, group_select, addr_bus};
  assign datPins = {dataIn, upper_byte_mask, lower_byte_mask, lower_strobe, 1'b0};

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmdS1_r <= '0;
      cmdS2_r <= '0;
      cmdS3_r <= '0;
      cmdF_r <= '0;
      cmdPrev_r <= '0;
    end
    else
    begin
      cmdS1_r <= cmdPins;
      cmdS2_r <= cmdS1_r;
      cmdS3_r <= cmdS2_r;
      cmdF_r <= (cmdS3_r & ~(cmdS2_r ^ cmdS3_r)) | (cmdF_r & (cmdS2_r ^ cmdS3_r));
      cmdPrev_r <= cmdF_r;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      datS1_r <= '0;
      datS2_r <= '0;
      datS3_r <= '0;
      datF_r <= '0;
      datPrev_r <= '0;
    end
    else
    begin
      datS1_r <= datPins;
      datS2_r <= datS1_r;
      datS3_r <= datS2_r;
      datF_r <= (datS3_r & ~(datS2_r ^ datS3_r)) | (datF_r & (datS2_r ^ datS3_r));
      datPrev_r <= datF_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at the clock crossing
  logic fClk, fClkN, fSelN, fRasN, fCasN, fWeN, fTerm;
  logic [1:0] fBank;
  logic [12:0] fAddr;
  logic crossing, sampleEdge, decodeEn;
  ddr2c_pkg::ddr2c_cmd_t decoded;

  assign {fClk, fClkN, fSelN, fRasN, fCasN, fWeN, fTerm, fBank, fAddr} = cmdF_r;
  assign crossing = fClk & ~fClkN;
  assign sampleEdge = crossing & ~(cmdPrev_r[SYNC_W-1] & ~cmdPrev_r[SYNC_W-2]); // see R15

  always_comb
  begin
    decoded = ddr2c_pkg::DDR2C_NOP;
    if (!fSelN) // see R01
    begin
      unique case ({fRasN, fCasN, fWeN}) // see R02
        3'h0: decoded = ddr2c_pkg::DDR2C_MODE;
        3'h1: decoded = ddr2c_pkg::DDR2C_REFRESH;
        3'h2: decoded = ddr2c_pkg::DDR2C_PRECH;
        3'h3: decoded = ddr2c_pkg::DDR2C_ACT;
        3'h4: decoded = ddr2c_pkg::DDR2C_WRITE;
        3'h5: decoded = ddr2c_pkg::DDR2C_READ;
        default: decoded = ddr2c_pkg::DDR2C_NOP; // see R18
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmdValid <= 1'b0;
      cmdCode <= 3'h0;
      cmdBank <= 2'h0;
      cmdAddr <= 13'h0000;
      cmdAllBanks <= 1'b0;
      cmdAutoPre <= 1'b0;
    end
    else
    begin
      cmdValid <= sampleEdge & decodeEn & (decoded != ddr2c_pkg::DDR2C_NOP); // see R19
      if (sampleEdge)
      begin
        cmdCode <= decoded;
        cmdBank <= fBank; // see R08
        cmdAddr <= (decoded == ddr2c_pkg::DDR2C_READ || decoded == ddr2c_pkg::DDR2C_WRITE)
                   ? {3'h0, fAddr[ddr2c_pkg::COL_W-1:0]} : fAddr; // see R10 R11
        cmdAllBanks <= (decoded == ddr2c_pkg::DDR2C_PRECH) & fAddr[ddr2c_pkg::AP_BIT]; // see R12
        cmdAutoPre <= (decoded == ddr2c_pkg::DDR2C_READ || decoded == ddr2c_pkg::DDR2C_WRITE)
                      & fAddr[ddr2c_pkg::AP_BIT]; // see R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank state and mode registers
  logic [ddr2c_pkg::BANKS-1:0] bankOpen_r;
  logic [12:0] openRow_r [ddr2c_pkg::BANKS];
  logic [12:0] modeReg_r, ext1Reg_r;
  logic [31:0] cmdCount_r;
  logic take;

  assign take = sampleEdge & decodeEn;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      bankOpen_r <= '0;
    else if (take && decoded == ddr2c_pkg::DDR2C_ACT)
      bankOpen_r[fBank] <= 1'b1;
    else if (take && decoded == ddr2c_pkg::DDR2C_PRECH)
    begin
      if (fAddr[ddr2c_pkg::AP_BIT])
        bankOpen_r <= '0; // see R12
      else
        bankOpen_r[fBank] <= 1'b0; // see R13
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int b = 0; b < ddr2c_pkg::BANKS; b++)
        openRow_r[b] <= 13'h0000;
    end
    else if (take && decoded == ddr2c_pkg::DDR2C_ACT)
      openRow_r[fBank] <= fAddr; // see R10
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      modeReg_r <= ddr2c_pkg::MODE_RST;
      ext1Reg_r <= ddr2c_pkg::EXT1_RST;
    end
    else if (take && decoded == ddr2c_pkg::DDR2C_MODE)
    begin
      if (fBank == ddr2c_pkg::SEL_BASE) // see R09
        modeReg_r <= fAddr; // see R14
      else if (fBank == ddr2c_pkg::SEL_EXT1)
        ext1Reg_r <= fAddr; // see R14
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cmdCount_r <= 32'h00000000;
    else if (take && decoded != ddr2c_pkg::DDR2C_NOP)
      cmdCount_r <= cmdCount_r + 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination and strobe mode
  logic termOff;
  logic termLevel_r;

  assign termOff = ~ext1Reg_r[ddr2c_pkg::RTT_LO_BIT] & ~ext1Reg_r[ddr2c_pkg::RTT_HI_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      termLevel_r <= 1'b0;
    else if (sampleEdge)
      termLevel_r <= fTerm; // see R03
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      termApply <= '0;
      strobeDiff <= 1'b1;
    end
    else
    begin
      termApply <= {22{termLevel_r & ~termOff}}; // see R03 R04 R05
      strobeDiff <= ~ext1Reg_r[ddr2c_pkg::STROBE_SE_BIT]; // see R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write beats on both strobe edges
  logic [3:0] beatsLeft_r;
  logic strobeEdge;
  logic [3:0] burstLen;

  assign strobeEdge = datF_r[1] ^ datPrev_r[1]; // see R07
  assign burstLen = (modeReg_r[ddr2c_pkg::BL_LSB +: 3] == ddr2c_pkg::BL_EIGHT) ? 4'h8 : 4'h4;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      beatsLeft_r <= 4'h0;
    else if (take && decoded == ddr2c_pkg::DDR2C_WRITE)
      beatsLeft_r <= burstLen;
    else if (strobeEdge && beatsLeft_r != 4'h0)
      beatsLeft_r <= beatsLeft_r - 4'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      beatValid <= 1'b0;
      beatData <= 16'h0000;
      beatByteEn <= 2'h0;
    end
    else
    begin
      beatValid <= strobeEdge & (beatsLeft_r != 4'h0) & (datF_r[3:2] != 2'h3);
      if (strobeEdge)
      begin
        beatData <= datF_r[DATA_W-1:4];
        beatByteEn <= ~datF_r[3:2]; // see R06 R07
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHeld_r, wHeld_r;
  logic [31:0] ctrl_r;
  logic doWrite;
  logic [31:0] rdVal;
  logic rdOk;

  assign decodeEn = ctrl_r[ddr2c_pkg::CTRL_EN_BIT];
  assign doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ddr2c_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r == ddr2c_pkg::OFS_CTRL) ? ddr2c_pkg::RESP_OKAY : ddr2c_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ctrl_r <= ddr2c_pkg::CTRL_RST;
    else if (doWrite && awAddr_r == ddr2c_pkg::OFS_CTRL)
      ctrl_r <= merge(ctrl_r, wData_r, wStrb_r) & 32'h00000001;
  end

  always_comb
  begin
    rdVal = 32'h00000000;
    rdOk = 1'b1;
    unique case (s_axi_araddr)
      ddr2c_pkg::OFS_CTRL: rdVal = ctrl_r;
      ddr2c_pkg::OFS_STATUS: rdVal = {26'h0, strobeDiff, termApply[0], bankOpen_r};
      ddr2c_pkg::OFS_LASTCMD: rdVal = {11'h0, cmdAutoPre, cmdAllBanks, cmdCode, cmdBank, 1'b0, cmdAddr};
      ddr2c_pkg::OFS_MODE: rdVal = {19'h0, modeReg_r};
      ddr2c_pkg::OFS_EXT1: rdVal = {19'h0, ext1Reg_r};
      ddr2c_pkg::OFS_CMDCNT: rdVal = cmdCount_r;
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ddr2c_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdVal;
      s_axi_rresp <= rdOk ? ddr2c_pkg::RESP_OKAY : ddr2c_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// file: bench/ddr2c_cad_monitor.sv
// Concurrent checks on the decoded bundle, termination and write answers.
// Assumes pins stay stable for at least eight clk_sys cycles around a memory clock rise.
module ddr2c_cad_monitor
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic selectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic [1:0] group_select,
  input wire logic [12:0] addr_bus,
  input wire logic cmdValid,
  input wire logic [2:0] cmdCode,
  input wire logic [1:0] cmdBank,
  input wire logic [12:0] cmdAddr,
  input wire logic cmdAllBanks,
  input wire logic cmdAutoPre,
  input wire logic [21:0] termApply,
  input wire logic beatValid,
  input wire logic [1:0] beatByteEn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_sel_masks: assert property (selectN [*8] |-> !cmdValid)
    else $error("command decoded while deselected");
  a_nop_combo: assert property ((rowStrobeN && colStrobeN) [*8] |-> !cmdValid)
    else $error("no-operation strobe pattern produced a command");
  a_code_known: assert property (cmdValid |-> cmdCode inside {[3'h1:3'h6]})
    else $error("valid command carries no command class");
  a_valid_pulse: assert property (cmdValid |=> !cmdValid)
    else $error("command valid longer than one cycle");
  a_act_row: assert property (($stable(addr_bus) && $stable(group_select)) [*8] ##0
    (cmdValid && cmdCode == ddr2c_pkg::DDR2C_ACT) |-> cmdAddr == addr_bus && cmdBank == group_select)
    else $error("activate row or bank wrong");
  a_rdwr_col: assert property (($stable(addr_bus) && $stable(group_select)) [*8] ##0
    (cmdValid && cmdCode inside {ddr2c_pkg::DDR2C_READ, ddr2c_pkg::DDR2C_WRITE}) |->
    cmdAddr == {3'h0, addr_bus[9:0]} && cmdAutoPre == addr_bus[10] && cmdBank == group_select)
    else $error("column, auto precharge or bank wrong");
  a_prech_scope: assert property (($stable(addr_bus) && $stable(group_select)) [*8] ##0
    (cmdValid && cmdCode == ddr2c_pkg::DDR2C_PRECH) |->
    cmdAllBanks == addr_bus[10] && (addr_bus[10] || cmdBank == group_select))
    else $error("precharge scope or bank wrong");
  a_term_uniform: assert property (termApply == 22'h000000 || termApply == 22'h3fffff)
    else $error("termination not applied to all lines alike");
  a_beat_bytes: assert property (beatValid |-> beatByteEn != 2'h0)
    else $error("fully masked beat passed on");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule

bind ddr2_cad ddr2c_cad_monitor ddr2c_cad_monitor_i (.clk_sys, .reset, .selectN, .rowStrobeN, .colStrobeN,
  .group_select, .addr_bus, .cmdValid, .cmdCode, .cmdBank, .cmdAddr, .cmdAllBanks, .cmdAutoPre, .termApply,
  .beatValid, .beatByteEn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);

// file: bench/ddr2c_ctrl_model.sv
// Memory controller model driving command, address and write data pins.
// Assumes tasks are called right after a rising clk_sys edge.
module ddr2c_ctrl_model
(
  input wire logic clk_sys,
  output logic memClk,
  output logic memClkN,
  output logic selectN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeStrobeN,
  output logic termination_control,
  output logic [1:0] group_select,
  output logic [12:0] addr_bus,
  output logic [15:0] dataIn,
  output logic lower_byte_mask,
  output logic upper_byte_mask,
  output logic lower_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {memClk, memClkN, selectN, rowStrobeN, colStrobeN, writeStrobeN} = 6'h1f;
    {termination_control, group_select, addr_bus, dataIn} = 32'h0;
    {lower_byte_mask, upper_byte_mask, lower_strobe} = 3'h0;
  end

  // One memory clock frame; the clock stands still between frames
  task automatic send(input logic sn, input logic [2:0] rcw, input logic [1:0] ba, input logic [12:0] a,
    input logic t);
    {selectN, rowStrobeN, colStrobeN, writeStrobeN} <= {sn, rcw};
    group_select <= ba;
    addr_bus <= a;
    termination_control <= t;
    repeat (5) @(posedge clk_sys);
    {memClk, memClkN} <= 2'b10;
    repeat (5) @(posedge clk_sys);
    {memClk, memClkN} <= 2'b01;
    repeat (4) @(posedge clk_sys);
    selectN <= 1'b1;
    addr_bus <= ~a;
    @(posedge clk_sys);
  endtask

  // One write beat: masks given with every beat, strobe toggles mid-data
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    dataIn <= d;
    {upper_byte_mask, lower_byte_mask} <= m;
    repeat (4) @(posedge clk_sys);
    lower_strobe <= ~lower_strobe;
    repeat (4) @(posedge clk_sys);
    dataIn <= ~d;
    @(posedge clk_sys);
  endtask
endmodule

// file: bench/ddr2_cad_tb_top.sv
// Testbench of the command and address decoder with register access.
// Assumes the controller model and the bound checker sit beside the design.
module ddr2_cad_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic memClk, memClkN, selectN, rowStrobeN, colStrobeN, writeStrobeN, termination_control;
  logic lower_byte_mask, upper_byte_mask, lower_strobe, cmdValid, cmdAllBanks, cmdAutoPre, strobeDiff, beatValid;
  logic [1:0] group_select, cmdBank, beatByteEn, s_axi_bresp, s_axi_rresp;
  logic [12:0] addr_bus, cmdAddr;
  logic [15:0] dataIn, beatData;
  logic [2:0] cmdCode;
  logic [21:0] termApply;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [2:0] lCode;
  logic [1:0] lBank;
  logic [12:0] lAddr;
  logic lAll, lAp;
  logic [17:0] beatQ[$];
  int num_errors = 0, checked = 0, cyc = 0, nCmd = 0;
  localparam logic [2:0] RCW[8] = '{3'h3, 3'h5, 3'h0, 3'h2, 3'h1, 3'h7, 3'h6, 3'h4};
  localparam ddr2c_pkg::ddr2c_cmd_t CMDS[8] = '{ddr2c_pkg::DDR2C_ACT, ddr2c_pkg::DDR2C_READ,
    ddr2c_pkg::DDR2C_MODE, ddr2c_pkg::DDR2C_PRECH, ddr2c_pkg::DDR2C_REFRESH, ddr2c_pkg::DDR2C_NOP,
    ddr2c_pkg::DDR2C_NOP, ddr2c_pkg::DDR2C_WRITE};

  ddr2_cad ddr2_cad_i (.clk_sys, .reset, .memClk, .memClkN, .selectN, .rowStrobeN, .colStrobeN, .writeStrobeN,
    .termination_control, .group_select, .addr_bus, .dataIn, .lower_byte_mask, .upper_byte_mask, .lower_strobe,
    .cmdValid, .cmdCode, .cmdBank, .cmdAddr, .cmdAllBanks, .cmdAutoPre, .termApply, .strobeDiff, .beatValid,
    .beatData, .beatByteEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ddr2c_ctrl_model ddr2c_ctrl_model_i (.clk_sys, .memClk, .memClkN, .selectN, .rowStrobeN, .colStrobeN,
    .writeStrobeN, .termination_control, .group_select, .addr_bus, .dataIn, .lower_byte_mask, .upper_byte_mask,
    .lower_strobe);

  always #4 clk_sys = ~clk_sys;

  // Records decoded commands and write beats; cuts a hang short
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cmdValid === 1'b1)
    begin
      nCmd++;
      {lCode, lBank, lAddr, lAll, lAp} = {cmdCode, cmdBank, cmdAddr, cmdAllBanks, cmdAutoPre};
    end
    if (beatValid === 1'b1)
      beatQ.push_back({beatByteEn, beatData});
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("errors %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic p;
    p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (p)
    begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) p = 1'b0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic p;
    p = 1'b1;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (p)
    begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) p = 1'b0;
    end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(ddr2c_pkg::RESP_OKAY));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [12:0] a;
    int n0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdChk(ddr2c_pkg::OFS_CTRL, ddr2c_pkg::CTRL_RST);
    rdChk(ddr2c_pkg::OFS_MODE, 32'(ddr2c_pkg::MODE_RST));
    rdChk(ddr2c_pkg::OFS_EXT1, 32'(ddr2c_pkg::EXT1_RST));
    rdChk(ddr2c_pkg::OFS_STATUS, 32'h00000020);
    rd(8'h18, d, r);
    chk(32'(r), 32'(ddr2c_pkg::RESP_SLVERR));
    wr(ddr2c_pkg::OFS_STATUS, 32'h000000ff, r);
    chk(32'(r), 32'(ddr2c_pkg::RESP_SLVERR));
    s_axi_wstrb <= 4'he;
    wr(ddr2c_pkg::OFS_CTRL, 32'h0, r);
    s_axi_wstrb <= 4'hf;
    chk(32'(r), 32'(ddr2c_pkg::RESP_OKAY));
    rdChk(ddr2c_pkg::OFS_CTRL, ddr2c_pkg::CTRL_RST);
    rdChk(ddr2c_pkg::OFS_STATUS, 32'h00000020);
    for (int i = 0; i < 8; i++)
    begin
      n0 = nCmd;
      a = 13'h0a5a ^ {i[2:0], 10'h000};
      ddr2c_ctrl_model_i.send(1'b0, RCW[i], i[1:0], a, 1'b0);
      chk(32'(nCmd - n0), 32'(CMDS[i] != ddr2c_pkg::DDR2C_NOP));
      if (CMDS[i] != ddr2c_pkg::DDR2C_NOP)
      begin
        chk(32'(lCode), 32'(CMDS[i]));
        chk(32'(lBank), 32'(i[1:0]));
        chk(32'(lAddr), 32'((RCW[i][1:0] == 2'h0 || RCW[i] == 3'h5) && RCW[i] != 3'h0 ? {3'h0, a[9:0]} : a));
      end
      if (CMDS[i] == ddr2c_pkg::DDR2C_PRECH) chk(32'(lAll), 32'(a[10]));
      if (CMDS[i] == ddr2c_pkg::DDR2C_READ) chk(32'(lAp), 32'(a[10]));
    end
    for (int i = 0; i < 4; i++)
      ddr2c_ctrl_model_i.beat({4{4'(i + 3)}}, i[1:0]);
    repeat (8) @(posedge clk_sys);
    chk(32'(beatQ.size()), 32'h3);
    for (int i = 0; i < 3; i++)
      chk(32'(beatQ.pop_front()), 32'({~i[1:0], {4{4'(i + 3)}}}));
    ddr2c_ctrl_model_i.send(1'b0, 3'h3, 2'h1, 13'h0011, 1'b0);
    ddr2c_ctrl_model_i.send(1'b0, 3'h3, 2'h2, 13'h0022, 1'b0);
    ddr2c_ctrl_model_i.send(1'b0, 3'h2, 2'h1, 13'h0000, 1'b0);
    chk(32'(lAll), 32'h0);
    rdChk(ddr2c_pkg::OFS_STATUS, 32'h00000024);
    rd(ddr2c_pkg::OFS_LASTCMD, d, r);
    chk(d & 32'h000fffff, 32'h00034000);
    n0 = nCmd;
    ddr2c_ctrl_model_i.send(1'b1, 3'h3, 2'h0, 13'h0100, 1'b0);
    chk(32'(nCmd - n0), 32'h0);
    wr(ddr2c_pkg::OFS_CTRL, 32'h0, r);
    ddr2c_ctrl_model_i.send(1'b0, 3'h3, 2'h0, 13'h0100, 1'b0);
    chk(32'(nCmd - n0), 32'h0);
    wr(ddr2c_pkg::OFS_CTRL, ddr2c_pkg::CTRL_RST, r);
    ddr2c_ctrl_model_i.send(1'b0, 3'h7, 2'h0, 13'h0000, 1'b1);
    chk(32'(termApply), 32'h0);
    ddr2c_ctrl_model_i.send(1'b0, 3'h0, 2'h1, 13'h0404, 1'b0);
    rdChk(ddr2c_pkg::OFS_EXT1, 32'h00000404);
    chk(32'(strobeDiff), 32'h0);
    ddr2c_ctrl_model_i.send(1'b0, 3'h7, 2'h0, 13'h0000, 1'b1);
    chk(32'(termApply), 32'h003fffff);
    ddr2c_ctrl_model_i.send(1'b0, 3'h7, 2'h0, 13'h0000, 1'b0);
    chk(32'(termApply), 32'h0);
    ddr2c_ctrl_model_i.send(1'b0, 3'h0, 2'h0, 13'h0003, 1'b0);
    rdChk(ddr2c_pkg::OFS_MODE, 32'h00000003);
    ddr2c_ctrl_model_i.send(1'b0, 3'h4, 2'h0, 13'h0000, 1'b0);
    for (int i = 0; i < 9; i++)
      ddr2c_ctrl_model_i.beat(16'h00ff, 2'h0);
    repeat (8) @(posedge clk_sys);
    chk(32'(beatQ.size()), 32'h8);
    chk(32'(beatQ.pop_back()), 32'h000300ff);
    give_verdict();
  end
endmodule
